/* verilog/poi_defines.svh */
// Timing counts and mode codes for the pulse output and origin search block.
`ifndef POI_DEFINES_SVH
`define POI_DEFINES_SVH
`define POI_CLK_HZ         25000000
`define POI_CLR_TIME_US    10
`define POI_CLR_CYCLES     ((`POI_CLR_TIME_US * `POI_CLK_HZ) / 1000000)
`define POI_CLR_CNT_W      16
`define POI_MODE_ZERO      2'h0
`define POI_MODE_ONE       2'h1
`define POI_MODE_TWO       2'h2
`endif

/* verilog/poi_pkg.sv */
// Types shared by the pulse output and origin search block.
package poi_pkg;
  typedef enum logic [1:0] {
    POI_FMT_CWCCW   = 2'h0,
    POI_FMT_PULSDIR = 2'h1
  } poi_fmt_t;
  typedef enum logic [3:0] {
    POI_S_IDLE  = 4'b0001,
    POI_S_SEEK  = 4'b0010,
    POI_S_SETTL = 4'b0100,
    POI_S_DONE  = 4'b1000
  } poi_state_t;
endpackage

/* verilog/poi_sync.sv */
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/1ps
module poi_sync (
  // Clock and reset.
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic clkEn,
  // Pin and its filtered level.
  input  wire logic pinIn,
  output logic      level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // The first stage feeds only the second, so a metastable value never reaches logic.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s1_q  <= 1'b0;
      s2_q  <= 1'b0;
      s3_q  <= 1'b0;
      level <= 1'b0;
    end else if (clkEn) begin
      s1_q <= pinIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level <= s3_q;
      end
    end
  end
endmodule

/* verilog/poi_pulse_origin.sv */
// Pulse output channel with origin search handshakes.
`timescale 1ns/1ps
`include "poi_defines.svh"
// =====================================================================
module poi_pulse_origin (
  // Clock, reset and enable.
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  input  wire logic              clkEn,
  // Configuration.
  input  wire poi_pkg::poi_fmt_t outFormat,
  input  wire logic [1:0]        opMode,
  // Pulse requests from the pulse generator.
  input  wire logic              pulseReq,
  input  wire logic              dirCw,
  // Origin search control and status.
  input  wire logic              searchStart,
  input  wire logic              cwLimit,
  input  wire logic              ccwLimit,
  output logic                   searchBusy,
  output logic                   searchDone,
  output logic                   searchError,
  output logic                   originFixed,
  // Drive side pins and the near-origin seen flag.
  input  wire logic              origin_in,
  input  wire logic              origin_near_in,
  input  wire logic              pos_done_in,
  output logic                   pulse_train_out,
  output logic                   cw_pulse_out,
  output logic                   ccw_or_dir_out,
  output logic                   err_cnt_clear_out,
  output logic                   nearSeen
);
  import poi_pkg::*;

  // =====================================================================
  // Pin synchronisers
  logic originLvl;
  logic nearLvl;
  logic posDoneLvl;
  logic originPrev_q;
  logic originRise;

  poi_sync uOrigin (.sys_clk(sys_clk), .rstn(rstn), .clkEn(clkEn), .pinIn(origin_in), .level(originLvl));
  poi_sync uNear (.sys_clk(sys_clk), .rstn(rstn), .clkEn(clkEn), .pinIn(origin_near_in), .level(nearLvl));
  poi_sync uDone (.sys_clk(sys_clk), .rstn(rstn), .clkEn(clkEn), .pinIn(pos_done_in), .level(posDoneLvl));

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      originPrev_q <= 1'b0;
    end else if (clkEn) begin
      originPrev_q <= originLvl;
    end
  end
  assign originRise = originLvl & ~originPrev_q;

  // =====================================================================
  // Pulse outputs
  // A pulse toward a limit that is active is blocked, so the motor never drives into it.
  logic pulseOk;
  assign pulseOk = pulseReq & ~(dirCw ? cwLimit : ccwLimit);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pulse_train_out <= 1'b0;
      cw_pulse_out    <= 1'b0;
      ccw_or_dir_out  <= 1'b0;
    end else if (clkEn) begin
      if (outFormat == POI_FMT_CWCCW) begin
        pulse_train_out <= 1'b0;
        cw_pulse_out    <= pulseOk & dirCw;
        ccw_or_dir_out  <= pulseOk & ~dirCw;
      end else begin
        pulse_train_out <= pulseOk;
        cw_pulse_out    <= 1'b0;
        ccw_or_dir_out  <= dirCw;
      end
    end
  end

  // =====================================================================
  // Origin search sequencer
  poi_state_t stateQ;
  logic       clrStart;
  logic       fixNow;
  assign fixNow   = (stateQ == POI_S_SEEK) && originRise;
  assign clrStart = fixNow && (opMode != `POI_MODE_ZERO);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      stateQ <= POI_S_IDLE;
    end else if (clkEn) begin
      case (stateQ)
        POI_S_IDLE: begin
          if (searchStart && opMode != 2'h3) begin
            stateQ <= POI_S_SEEK;
          end
        end
        POI_S_SEEK: begin
          if (fixNow) begin
            stateQ <= (opMode == `POI_MODE_TWO) ? POI_S_SETTL : POI_S_DONE;
          end
        end
        POI_S_SETTL: begin
          if (posDoneLvl && !err_cnt_clear_out) begin
            stateQ <= POI_S_DONE;
          end
        end
        POI_S_DONE: begin
          if (searchStart && opMode != 2'h3) begin
            stateQ <= POI_S_SEEK;
          end
        end
        default: stateQ <= POI_S_IDLE;
      endcase
    end
  end

  always_comb begin
    searchBusy = (stateQ == POI_S_SEEK) || (stateQ == POI_S_SETTL);
    searchDone = (stateQ == POI_S_DONE);
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      searchError <= 1'b0;
      originFixed <= 1'b0;
      nearSeen    <= 1'b0;
    end else if (clkEn) begin
      searchError <= searchStart && (stateQ == POI_S_IDLE || stateQ == POI_S_DONE) && opMode == 2'h3;
      if (searchStart && !searchBusy) begin
        originFixed <= 1'b0;
        nearSeen    <= 1'b0;
      end else begin
        if (fixNow) begin
          originFixed <= 1'b1;
        end
        if (searchBusy && nearLvl) begin
          nearSeen <= 1'b1;
        end
      end
    end
  end

  // =====================================================================
  // Error counter clear pulse
  // A fixed width keeps the drive's clear input honoured regardless of scan timing.
  logic [`POI_CLR_CNT_W-1:0] clrCnt_q;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      clrCnt_q          <= 16'h0000;
      err_cnt_clear_out <= 1'b0;
    end else if (clkEn) begin
      if (clrStart) begin
        clrCnt_q          <= `POI_CLR_CNT_W'(`POI_CLR_CYCLES - 1);
        err_cnt_clear_out <= 1'b1;
      end else if (clrCnt_q != 16'h0000) begin
        clrCnt_q <= clrCnt_q - 16'h0001;
      end else begin
        err_cnt_clear_out <= 1'b0;
      end
    end
  end

  // =====================================================================
  // Assertions
  // Enabled cycles that the clear output has stood high, counted apart from the pulse counter.
  logic [`POI_CLR_CNT_W-1:0] clrLen_q;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      clrLen_q <= 16'h0000;
    end else if (clkEn) begin
      if (clrStart) begin
        clrLen_q <= 16'h0000;
      end else if (err_cnt_clear_out) begin
        clrLen_q <= clrLen_q + 16'h0001;
      end else begin
        clrLen_q <= 16'h0000;
      end
    end
  end

  a_dir_level: assert property (@(posedge sys_clk) disable iff (!rstn)
    clkEn && outFormat == POI_FMT_PULSDIR && $stable(outFormat) |=> ccw_or_dir_out == $past(dirCw))
    else $error("direction level wrong");
  a_cw_separate: assert property (@(posedge sys_clk) disable iff (!rstn)
    outFormat == POI_FMT_CWCCW && $past(outFormat) == POI_FMT_CWCCW |-> !(cw_pulse_out && ccw_or_dir_out))
    else $error("cw and ccw both on");
  a_idle_off: assert property (@(posedge sys_clk) disable iff (!rstn)
    clkEn && !pulseReq |=> !pulse_train_out && !cw_pulse_out)
    else $error("pulse without request");
  a_pd_pulse: assert property (@(posedge sys_clk) disable iff (!rstn)
    clkEn && outFormat == POI_FMT_PULSDIR && pulseOk |=> pulse_train_out)
    else $error("pulse train missing");
  a_mode0_noclr: assert property (@(posedge sys_clk) disable iff (!rstn)
    clkEn && opMode == `POI_MODE_ZERO && fixNow |=> !err_cnt_clear_out && searchDone)
    else $error("mode 0 handling wrong");
  a_clr_on_fix: assert property (@(posedge sys_clk) disable iff (!rstn)
    clrStart && clkEn |=> err_cnt_clear_out)
    else $error("clear not raised");
  a_mode2_wait: assert property (@(posedge sys_clk) disable iff (!rstn)
    stateQ == POI_S_SETTL && !posDoneLvl |=> !searchDone)
    else $error("mode 2 finished early");
  a_settle_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
    stateQ == POI_S_SETTL && (!posDoneLvl || !clkEn) |=> stateQ == POI_S_SETTL)
    else $error("search left without completion");
  a_clr_width: assert property (@(posedge sys_clk) disable iff (!rstn)
    clkEn && clrCnt_q == 16'h0000 && !clrStart |=> !err_cnt_clear_out)
    else $error("clear pulse too long");
  a_clr_length: assert property (@(posedge sys_clk) disable iff (!rstn)
    $fell(err_cnt_clear_out) |-> clrLen_q == `POI_CLR_CNT_W'(`POI_CLR_CYCLES))
    else $error("clear pulse length wrong");
  a_bad_mode: assert property (@(posedge sys_clk) disable iff (!rstn)
    clkEn && searchStart && !searchBusy && opMode == 2'h3 |=> searchError && !searchBusy)
    else $error("illegal mode accepted");

  c_mode0: cover property (@(posedge sys_clk) disable iff (!rstn) fixNow && opMode == `POI_MODE_ZERO);
  c_mode1: cover property (@(posedge sys_clk) disable iff (!rstn) fixNow && opMode == `POI_MODE_ONE);
  c_mode2: cover property (@(posedge sys_clk) disable iff (!rstn) stateQ == POI_S_SETTL ##1 stateQ == POI_S_DONE);
  c_clr_end: cover property (@(posedge sys_clk) disable iff (!rstn) $fell(err_cnt_clear_out));
  c_bad_mode: cover property (@(posedge sys_clk) disable iff (!rstn) searchError);
endmodule

/* verification/poi_drive_model.sv */
// Drive model: phase-Z origin pulse and positioning completed output.
`timescale 1ns/1ps
module poi_drive_model #(
  parameter int ZW     = 6,
  parameter int SETTLE = 8
) (
  // Clock and reset.
  input  wire logic sys_clk,
  input  wire logic rstn,
  // Bench commands and step activity.
  input  wire logic zReq,
  input  wire logic stall,
  input  wire logic stepIn,
  // Drive outputs.
  output logic      origin_in,
  output logic      pos_done_in
);
  int zCnt;
  int idleCnt;
  // =====================================================================
  // Stall keeps the motor out of position, a slow answer.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) idleCnt <= 0;
    else if (stall || stepIn) idleCnt <= 0;
    else if (idleCnt < SETTLE) idleCnt <= idleCnt + 1;
  end
  assign pos_done_in = (idleCnt >= SETTLE);
  // =====================================================================
  // Phase-Z is a short pulse per request.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) zCnt <= 0;
    else if (zReq) zCnt <= ZW;
    else if (zCnt > 0) zCnt <= zCnt - 1;
  end
  assign origin_in = (zCnt > 0);
endmodule

/* verification/tb_top.sv */
// Self-checking bench for the pulse output and origin search block.
`timescale 1ns/1ps
`include "poi_defines.svh"
module tb_top;
  import poi_pkg::*;
  logic       sys_clk = 1'b0;
  logic       rstn    = 1'b0;
  poi_fmt_t   fmt     = POI_FMT_CWCCW;
  logic [1:0] mode    = 2'h0;
  logic       pReq    = 1'b0;
  logic       dir     = 1'b0;
  logic       start   = 1'b0;
  logic       cwLim   = 1'b0;
  logic       ccwLim  = 1'b0;
  logic       near    = 1'b0;
  logic       zReq    = 1'b0;
  logic       stall   = 1'b0;
  logic       en      = 1'b1;
  logic       busy, done, fixed, org, pdone, pt, cw, cd, clr, err, nearS;
  int         n_mismatch = 0;
  int         checked    = 0;
  int         cyc        = 0;
  always #20 sys_clk = ~sys_clk;
  poi_pulse_origin poi_pulse_origin_inst (.sys_clk(sys_clk), .rstn(rstn), .clkEn(en), .outFormat(fmt),
    .opMode(mode), .pulseReq(pReq), .dirCw(dir), .searchStart(start), .cwLimit(cwLim), .ccwLimit(ccwLim),
    .searchBusy(busy), .searchDone(done), .searchError(err), .originFixed(fixed), .origin_in(org),
    .origin_near_in(near), .pos_done_in(pdone), .pulse_train_out(pt), .cw_pulse_out(cw),
    .ccw_or_dir_out(cd), .err_cnt_clear_out(clr), .nearSeen(nearS));
  poi_drive_model poi_drive_model_inst (.sys_clk(sys_clk), .rstn(rstn), .zReq(zReq), .stall(stall),
    .stepIn(pt | cw | (cd & (fmt == POI_FMT_CWCCW))), .origin_in(org), .pos_done_in(pdone));
  // =====================================================================
  task automatic results;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [2:0] exp, input logic [2:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // Outputs are registered, so they are judged one cycle after the request.
  task automatic drv(input poi_fmt_t f, input logic r, input logic d);
    fmt = f;
    pReq = r;
    dir = d;
    step(1);
  endtask
  // =====================================================================
  task automatic t_fmt;
    drv(POI_FMT_CWCCW, 1'b1, 1'b1);
    chk("cw pins", 3'h2, {pt, cw, cd});
    drv(POI_FMT_CWCCW, 1'b1, 1'b0);
    chk("ccw pins", 3'h1, {pt, cw, cd});
    drv(POI_FMT_CWCCW, 1'b0, 1'b0);
    chk("idle pins", 3'h0, {pt, cw, cd});
    drv(POI_FMT_PULSDIR, 1'b1, 1'b1);
    chk("dir cw pins", 3'h5, {pt, cw, cd});
    drv(POI_FMT_PULSDIR, 1'b1, 1'b0);
    chk("dir ccw pins", 3'h4, {pt, cw, cd});
    drv(POI_FMT_PULSDIR, 1'b0, 1'b1);
    chk("dir idle pins", 3'h1, {pt, cw, cd});
    en = 1'b0;
    drv(POI_FMT_PULSDIR, 1'b1, 1'b0);
    chk("frozen pins", 3'h1, {pt, cw, cd});
    en = 1'b1;
    cwLim = 1'b1;
    drv(POI_FMT_CWCCW, 1'b1, 1'b1);
    chk("cw limited", 3'h0, {pt, cw, cd});
    cwLim = 1'b0;
    ccwLim = 1'b1;
    drv(POI_FMT_CWCCW, 1'b1, 1'b0);
    chk("ccw limited", 3'h0, {pt, cw, cd});
    ccwLim = 1'b0;
    drv(POI_FMT_CWCCW, 1'b0, 1'b0);
    $display("test formats done");
  endtask
  task automatic t_search(input logic [1:0] m);
    int n;
    mode = m;
    stall = (m == `POI_MODE_TWO);
    near = 1'b1;
    start = 1'b1;
    step(1);
    start = 1'b0;
    chk("busy", 3'h1, {2'h0, busy});
    zReq = 1'b1;
    step(1);
    zReq = 1'b0;
    n = 0;
    while (fixed !== 1'b1 && n < 20) begin
      step(1);
      n++;
    end
    chk("origin fixed", 3'h1, {2'h0, fixed});
    chk("clear on fix", {2'h0, m != `POI_MODE_ZERO}, {2'h0, clr});
    chk("done on fix", {2'h0, m != `POI_MODE_TWO}, {2'h0, done});
    n = 0;
    while (clr === 1'b1 && n < 400) begin
      step(1);
      n++;
    end
    chk("clear width", 3'h1, {2'h0, n == ((m == `POI_MODE_ZERO) ? 0 : `POI_CLR_CYCLES)});
    step(20);
    chk("done while moving", {2'h0, m != `POI_MODE_TWO}, {2'h0, done});
    stall = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 40) begin
      step(1);
      n++;
    end
    chk("done at rest", 3'h1, {2'h0, done});
    chk("near seen", 3'h1, {2'h0, nearS});
    near = 1'b0;
    $display("test search mode %0d done", m);
  endtask
  task automatic t_badmode;
    mode = 2'h3;
    start = 1'b1;
    step(1);
    start = 1'b0;
    chk("mode 3 refused", 3'h5, {err, busy, done});
    step(1);
    chk("mode 3 error ends", 3'h1, {err, busy, done});
    mode = `POI_MODE_ZERO;
    $display("test illegal mode done");
  endtask
  // =====================================================================
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end
  initial begin
    step(3);
    rstn = 1'b1;
    step(1);
    t_fmt();
    t_search(`POI_MODE_ZERO);
    t_search(`POI_MODE_ONE);
    t_search(`POI_MODE_TWO);
    t_badmode();
    results();
  end
endmodule
